// >>> include/amsb_defs.svh
// Constants of the addressable multidrop scan bridge
`ifndef AMSB_DEFS_SVH
`define AMSB_DEFS_SVH

`define AMSB_IR_W       8
`define AMSB_ADDR_W     6
`define AMSB_NPORT      3
`define AMSB_CAP_LSB    2'h1
`define AMSB_ADDR_LSB   2
`define AMSB_BCAST_ADDR 6'h3a
`define AMSB_MODE_RST   3'h1
`define AMSB_INS_BYPASS 8'hff
`define AMSB_INS_MODSEL 8'h8e
`define AMSB_INS_UNPARK 8'he7
`define AMSB_INS_PPARK  8'h8b
`define AMSB_INS_GOWAIT 8'hc3

`endif

// >>> include/amsb_pkg.sv
// Types of the addressable multidrop scan bridge
package amsb_pkg;

    typedef enum logic [3:0] {
        TLR, RTI, SEL_DR, CAP_DR, SH_DR, EX1_DR, PAU_DR, EX2_DR, UPD_DR,
        SEL_IR, CAP_IR, SH_IR, EX1_IR, PAU_IR, EX2_IR, UPD_IR
    } amsb_tap_t;

    // Where a parked local port rests
    typedef enum logic [1:0] {
        PK_IDLE, PK_PDR, PK_PIR
    } amsb_park_t;

    // Backplane pins after synchronising
    typedef struct packed {
        logic tck;
        logic tms;
        logic tdi;
        logic trstN;
    } amsb_bp_t;

endpackage

// >>> verilog/amsb_bridge.sv
// Addressable bridge from a multidrop backplane test bus to local scan ports
`timescale 1ns/100ps
`default_nettype none
`include "amsb_defs.svh"

// Behaviour
// R1 - Instruction capture loads slot address above the pattern 01.
// R2 - Controller treats matching returned capture as a selected bridge.
// R3 - Unselected bridges release return data so it reads all ones.
// R4 - Address matching slot inputs, shifted while waiting, selects the bridge.
// R5 - Mode-select instruction puts mode register in path; it picks ports.
// R6 - Mode register resets to the first local port alone.
// R7 - Enabled unparked local ports are concatenated into one chain.
// R8 - Connect instruction attaches a parked port on reaching its rest state (Run-Test/Idle after reset, else its pause state).
// R9 - Instruction, bypass and pad bits stay in the path while connected.
// R10 - Return-to-wait deselects the bridge and waits for an address.
// R11 - Reset on test reset low or on a clock in Test-Logic-Reset, reached by five clocks with mode select high.
// R12 - Pause-park: Exit1-DR to Update-DR parks port in Pause-DR.
// R13 - Return-to-wait via Exit1-IR to Update-IR parks port in Pause-IR.
// R14 - Pause-park reconnects a parked port in the matching pause state.
// R15 - Broadcast address selects every bridge at once.
// R16 - Three local ports, each parked or connected on its own.
// R17 - Controller updates external test on all cards via broadcast.
// R18 - Six-bit slot address compared, up to 63 bridges.
// R19 - A parked port's mode select is held to keep it stable.
module amsb_bridge #(
    parameter int NPORT = `AMSB_NPORT
) (
    // Clock and reset
    input  wire logic             clk,
    input  wire logic             reset_n,
    // Backplane test bus
    input  wire logic             bpTck,
    input  wire logic             bpTms,
    input  wire logic             bpTdi,
    input  wire logic             bpTrst_n,
    output logic                  bpTdo,
    output logic                  bpTdoOe_n,
    // Card slot address
    input  wire logic [5:0]       slotAddr,
    // Local scan ports
    output logic [NPORT-1:0]      lspTck,
    output logic [NPORT-1:0]      lspTms,
    output logic [NPORT-1:0]      lspTdi,
    input  wire logic [NPORT-1:0] lspTdo,
    // Status
    output logic                  selected
);

    amsb_pkg::amsb_bp_t   bpS1_r, bpS2_r;
    logic                 tckPrev_r;
    logic [5:0]           slotS1_r, slotS2_r;
    logic [NPORT-1:0]     tdoS1_r, tdoS2_r;

    amsb_pkg::amsb_tap_t  tap_r, tapNxt;
    logic [7:0]           ir_r;
    logic [7:0]           instr_r;
    logic                 sel_r, selAddr_r;
    logic [NPORT-1:0]     mode_r, modeSh_r;
    logic                 bypass_r, pad_r;
    logic [NPORT-1:0]     parked_r;
    amsb_pkg::amsb_park_t parkAt_r [NPORT];

    // Synchronisers; only second stages are read
    always_ff @(posedge clk) begin
        bpS1_r   <= '{tck: bpTck, tms: bpTms, tdi: bpTdi, trstN: bpTrst_n};
        bpS2_r   <= bpS1_r;
        slotS1_r <= slotAddr;
        slotS2_r <= slotS1_r;
        tdoS1_r  <= lspTdo;
        tdoS2_r  <= tdoS1_r;
        tckPrev_r <= bpS2_r.tck;
    end

    wire tckRise = bpS2_r.tck & ~tckPrev_r;
    wire tckFall = ~bpS2_r.tck & tckPrev_r;
    wire tms     = bpS2_r.tms;
    wire hardRst = ~reset_n | ~bpS2_r.trstN;                 // [R11]

    // Backplane TAP sequencing
    always_comb begin
        unique case (tap_r)
            amsb_pkg::TLR:    tapNxt = tms ? amsb_pkg::TLR    : amsb_pkg::RTI;
            amsb_pkg::RTI:    tapNxt = tms ? amsb_pkg::SEL_DR : amsb_pkg::RTI;
            amsb_pkg::SEL_DR: tapNxt = tms ? amsb_pkg::SEL_IR : amsb_pkg::CAP_DR;
            amsb_pkg::CAP_DR: tapNxt = tms ? amsb_pkg::EX1_DR : amsb_pkg::SH_DR;
            amsb_pkg::SH_DR:  tapNxt = tms ? amsb_pkg::EX1_DR : amsb_pkg::SH_DR;
            amsb_pkg::EX1_DR: tapNxt = tms ? amsb_pkg::UPD_DR : amsb_pkg::PAU_DR;
            amsb_pkg::PAU_DR: tapNxt = tms ? amsb_pkg::EX2_DR : amsb_pkg::PAU_DR;
            amsb_pkg::EX2_DR: tapNxt = tms ? amsb_pkg::UPD_DR : amsb_pkg::SH_DR;
            amsb_pkg::UPD_DR: tapNxt = tms ? amsb_pkg::SEL_DR : amsb_pkg::RTI;
            amsb_pkg::SEL_IR: tapNxt = tms ? amsb_pkg::TLR    : amsb_pkg::CAP_IR;
            amsb_pkg::CAP_IR: tapNxt = tms ? amsb_pkg::EX1_IR : amsb_pkg::SH_IR;
            amsb_pkg::SH_IR:  tapNxt = tms ? amsb_pkg::EX1_IR : amsb_pkg::SH_IR;
            amsb_pkg::EX1_IR: tapNxt = tms ? amsb_pkg::UPD_IR : amsb_pkg::PAU_IR;
            amsb_pkg::PAU_IR: tapNxt = tms ? amsb_pkg::EX2_IR : amsb_pkg::PAU_IR;
            amsb_pkg::EX2_IR: tapNxt = tms ? amsb_pkg::UPD_IR : amsb_pkg::SH_IR;
            amsb_pkg::UPD_IR: tapNxt = tms ? amsb_pkg::SEL_DR : amsb_pkg::RTI;
        endcase
    end

    // Decodes
    wire logic [5:0] irAddr   = ir_r[7:`AMSB_ADDR_LSB];
    wire logic       addrHit  = (irAddr == slotS2_r);                    // [R4] [R18]
    wire logic       bcastHit = (irAddr == `AMSB_BCAST_ADDR);            // [R15]
    wire logic       isModSel = (instr_r == `AMSB_INS_MODSEL);
    wire logic       isPPark  = (instr_r == `AMSB_INS_PPARK);
    wire logic       isUnpark = (instr_r == `AMSB_INS_UNPARK);
    wire logic       parkDr   = sel_r & isPPark & tms
                                & (tap_r == amsb_pkg::EX1_DR);           // [R12]
    wire logic       parkIr   = sel_r & tms & (tap_r == amsb_pkg::EX1_IR)
                                & (ir_r == `AMSB_INS_GOWAIT);            // [R13]
    wire logic       irScan   = (tap_r == amsb_pkg::SH_IR);
    wire logic       drScan   = (tap_r == amsb_pkg::SH_DR);
    wire logic       bridgeOut = irScan ? ir_r[0]
                               : (isModSel ? modeSh_r[0] : bypass_r);    // [R5] [R9]
    wire logic       drive    = sel_r & selAddr_r & (irScan | drScan);   // [R3]

    // Serial path through the pad bit and each enabled, connected port
    logic [NPORT:0]   chainSrc;
    logic [NPORT-1:0] inChain;
    always_comb begin
        chainSrc[0] = pad_r;                                             // [R9]
        for (int k = 0; k < NPORT; k++) begin
            inChain[k]    = mode_r[k] & ~parked_r[k];
            chainSrc[k+1] = inChain[k] ? tdoS2_r[k] : chainSrc[k];       // [R7]
        end
    end

    // Bridge registers on backplane clock rise
    always_ff @(posedge clk) begin
        if (hardRst || (tckRise && tap_r == amsb_pkg::TLR)) begin        // [R11]
            tap_r     <= amsb_pkg::TLR;
            ir_r      <= `AMSB_INS_BYPASS;
            instr_r   <= `AMSB_INS_BYPASS;
            sel_r     <= 1'b0;
            selAddr_r <= 1'b0;
            mode_r    <= NPORT'(`AMSB_MODE_RST);                         // [R6]
            modeSh_r  <= '0;
            bypass_r  <= 1'b0;
            pad_r     <= 1'b1;
            if (hardRst) begin
                tap_r <= amsb_pkg::TLR;
            end else begin
                tap_r <= tapNxt;
            end
        end else if (tckRise) begin
            tap_r <= tapNxt;
            if (irScan || drScan) begin
                pad_r <= bridgeOut;
            end
            unique case (tap_r)
                amsb_pkg::CAP_IR: ir_r <= {slotS2_r, `AMSB_CAP_LSB};     // [R1]
                amsb_pkg::SH_IR:  ir_r <= {bpS2_r.tdi, ir_r[7:1]};
                amsb_pkg::UPD_IR: begin
                    if (!sel_r) begin
                        sel_r     <= addrHit | bcastHit;                 // [R4] [R15]
                        selAddr_r <= addrHit & ~bcastHit;
                        instr_r   <= `AMSB_INS_BYPASS;
                    end else if (ir_r == `AMSB_INS_GOWAIT) begin
                        sel_r     <= 1'b0;                               // [R10]
                        selAddr_r <= 1'b0;
                        instr_r   <= `AMSB_INS_BYPASS;
                    end else begin
                        instr_r <= ir_r;
                    end
                end
                amsb_pkg::CAP_DR: begin
                    modeSh_r <= mode_r;
                    bypass_r <= 1'b0;
                end
                amsb_pkg::SH_DR: begin
                    if (isModSel) begin
                        modeSh_r <= {bpS2_r.tdi, modeSh_r[NPORT-1:1]};
                    end else begin
                        bypass_r <= bpS2_r.tdi;
                    end
                end
                amsb_pkg::UPD_DR: begin
                    if (sel_r && isModSel) begin
                        mode_r <= modeSh_r;                              // [R5]
                    end
                end
                default: ;
            endcase
        end
    end

    // Park and connect of each local port
    for (genvar k = 0; k < NPORT; k++) begin : g_port
        wire amsb_pkg::amsb_tap_t restState =
            (parkAt_r[k] == amsb_pkg::PK_PDR) ? amsb_pkg::PAU_DR :
            (parkAt_r[k] == amsb_pkg::PK_PIR) ? amsb_pkg::PAU_IR : amsb_pkg::RTI;
        wire logic connectNow = parked_r[k] & mode_r[k] & sel_r
                                & (isUnpark | isPPark)
                                & (tapNxt == restState);                 // [R8] [R14]
        wire logic parkNow = ~parked_r[k] & (parkDr | parkIr);

        always_ff @(posedge clk) begin
            if (hardRst || (tckRise && tap_r == amsb_pkg::TLR)) begin
                parked_r[k] <= 1'b1;
                parkAt_r[k] <= amsb_pkg::PK_IDLE;
            end else if (tckRise) begin
                if (connectNow) begin
                    parked_r[k] <= 1'b0;                                 // [R16]
                end else if (parkNow && parkDr) begin
                    parked_r[k] <= 1'b1;                                 // [R12]
                    parkAt_r[k] <= amsb_pkg::PK_PDR;
                end else if (parkNow) begin
                    parked_r[k] <= 1'b1;                                 // [R13]
                    parkAt_r[k] <= amsb_pkg::PK_PIR;
                end
            end
        end

        // Local mode select and data pins change on the backplane falling edge; local clock follows it
        always_ff @(posedge clk) begin
            if (!reset_n) begin
                lspTck[k] <= 1'b0;
                lspTms[k] <= 1'b0;
                lspTdi[k] <= 1'b1;
            end else begin
                lspTck[k] <= bpS2_r.tck;
                if (tckFall) begin
                    lspTms[k] <= (parked_r[k] | parkNow) ? 1'b0 : tms;   // [R19]
                    lspTdi[k] <= chainSrc[k];
                end
            end
        end
    end

    // Backplane return data
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            bpTdo     <= 1'b1;
            bpTdoOe_n <= 1'b1;
            selected  <= 1'b0;
        end else begin
            selected <= sel_r;
            if (tckFall) begin
                bpTdo     <= chainSrc[NPORT];
                bpTdoOe_n <= ~drive;                                     // [R3]
            end
        end
    end

endmodule
`default_nettype wire

// >>> test/amsb_ctrl_model.sv
// Behavioural backplane test controller
`timescale 1ns/100ps
`default_nettype none
module amsb_ctrl_model (
    // Backplane drive
    output var logic bpTck,
    output var logic bpTms,
    output var logic bpTdi,
    // Shared return line
    input  wire logic bpWire
);
    initial begin
        bpTck = 1'b0;
        bpTms = 1'b1;
        bpTdi = 1'b1;
    end
    // Clock stands low between steps
    task automatic step(input logic tms, input logic tdi, output logic tdo);
        bpTms = tms;
        bpTdi = tdi;
        #32;
        tdo = bpWire;
        bpTck = 1'b1;
        #32;
        bpTck = 1'b0;
    endtask
endmodule
`default_nettype wire

// >>> test/amsb_bridge_monitor.sv
// Port checker of the scan bridge
`timescale 1ns/100ps
`default_nettype none
module amsb_bridge_monitor #(
    parameter int NPORT = 3
) (
    input wire logic             clk,
    input wire logic             reset_n,
    input wire logic             bpTck,
    input wire logic             bpTms,
    input wire logic             bpTdi,
    input wire logic             bpTrst_n,
    input wire logic             bpTdo,
    input wire logic             bpTdoOe_n,
    input wire logic [5:0]       slotAddr,
    input wire logic [NPORT-1:0] lspTck,
    input wire logic [NPORT-1:0] lspTms,
    input wire logic [NPORT-1:0] lspTdi,
    input wire logic [NPORT-1:0] lspTdo,
    input wire logic             selected
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!reset_n);
    sequence tckHigh;
        $rose(bpTck) ##1 bpTck [*3];
    endsequence
    sequence portsIdle;
        (lspTms == '0) [*8];
    endsequence
    reset_out_a: assert property (disable iff (1'b0)
        !reset_n |=> bpTdoOe_n && !selected && lspTms == '0) else $error("outputs not reset");
    own_drive_a: assert property (!bpTdoOe_n |-> selected) else $error("drive unselected");
    oe_fall_a: assert property ($changed(bpTdoOe_n) |-> !bpTck) else $error("enable moved");
    tdo_fall_a: assert property ($changed(bpTdo) |-> !bpTck) else $error("tdo moved");
    lsp_fall_a: assert property (
        $changed({lspTms, lspTdi}) |-> !bpTck) else $error("local port moved off fall");
    sel_rise_a: assert property ($changed(selected) |-> bpTck) else $error("select moved");
    lsp_clock_a: assert property (
        tckHigh |-> ##[0:3] (lspTck == {NPORT{1'b1}})) else $error("local clock missing");
    parked_start_a: assert property ($rose(reset_n) |-> portsIdle) else $error("port live");
endmodule
bind amsb_bridge amsb_bridge_monitor #(.NPORT(NPORT)) u_amsb_bridge_monitor (
    .clk(clk), .reset_n(reset_n), .bpTck(bpTck), .bpTms(bpTms), .bpTdi(bpTdi),
    .bpTrst_n(bpTrst_n), .bpTdo(bpTdo), .bpTdoOe_n(bpTdoOe_n), .slotAddr(slotAddr),
    .lspTck(lspTck), .lspTms(lspTms), .lspTdi(lspTdi), .lspTdo(lspTdo), .selected(selected));
`default_nettype wire

// >>> test/test_addressable_multidrop_scan_bridge.sv
// Self-checking bench of the scan bridge
`timescale 1ns/100ps
`default_nettype none
`include "amsb_defs.svh"
module test_addressable_multidrop_scan_bridge;
    localparam logic [5:0] SLOT = 6'h15;
    logic       clk = 1'b0;
    logic       reset_n = 1'b0;
    logic       bpTck, bpTms, bpTdi, bpTdo, bpTdoOe_n, selected, dmy;
    logic [2:0] lspTck, lspTms, lspTdi;
    logic [8:0] got;
    wire logic  bpWire = bpTdoOe_n ? 1'b1 : bpTdo;
    int         mismatches = 0;
    int         checks_done = 0;
    int         cycles = 0;
    always #2.5 clk = ~clk;
    amsb_bridge u_amsb_bridge (.clk(clk), .reset_n(reset_n), .bpTck(bpTck), .bpTms(bpTms),
        .bpTdi(bpTdi), .bpTrst_n(1'b1), .bpTdo(bpTdo), .bpTdoOe_n(bpTdoOe_n),
        .slotAddr(SLOT), .lspTck(lspTck), .lspTms(lspTms), .lspTdi(lspTdi),
        .lspTdo(lspTdi), .selected(selected));
    amsb_ctrl_model u_amsb_ctrl_model (.bpTck(bpTck), .bpTms(bpTms), .bpTdi(bpTdi),
        .bpWire(bpWire));
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 8000) begin
            mismatches = mismatches + 1;
            final_report();
        end
    end
    task automatic final_report();
        $display("checks %0d mismatches %0d", checks_done, mismatches);
        if (mismatches == 0 && checks_done > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    task automatic chk(input logic [7:0] act, input logic [7:0] exp);
        checks_done = checks_done + 1;
        if (act !== exp) begin
            mismatches = mismatches + 1;
            $display("ERROR at %0t: got %h expected %h", $time, act, exp);
        end
    endtask
    // Mode select bits applied LSB first
    task automatic walk(input logic [7:0] tmsBits, input int n);
        for (int i = 0; i < n; i++) begin
            u_amsb_ctrl_model.step(tmsBits[i], 1'b0, dmy);
        end
    endtask
    // From Run-Test/Idle through an instruction scan and back
    // Nine shifts read a whole capture past the pad bit; extra bits are ones
    task automatic irScan(input logic [7:0] ins, input int n = 8);
        walk(8'h03, 4);
        for (int i = 0; i < n; i++) begin
            u_amsb_ctrl_model.step(i == n - 1, (i < 8) ? ins[i] : 1'b1, got[i]);
        end
        walk(8'h01, 2);
    endtask
    task automatic test_absent();
        irScan({~SLOT, 2'h0});
        chk(got[7:0], 8'hff);
        chk({7'h00, selected}, 8'h00);
    endtask
    task automatic test_select();
        irScan({SLOT, 2'h0});
        chk({7'h00, selected}, 8'h01);
        irScan(`AMSB_INS_BYPASS, 9);
        chk(got[8:1], {SLOT, 2'h1});
        irScan(`AMSB_INS_GOWAIT);
        chk({7'h00, selected}, 8'h00);
    endtask
    task automatic test_bcast();
        irScan({`AMSB_BCAST_ADDR, 2'h0});
        chk({7'h00, selected}, 8'h01);
        irScan(`AMSB_INS_GOWAIT);
        chk(got[7:0], 8'hff);
        chk({7'h00, selected}, 8'h00);
    endtask
    task automatic test_connect();
        irScan({SLOT, 2'h0});
        irScan(`AMSB_INS_UNPARK);
        walk(8'h02, 2);
        #30;
        chk({5'h00, lspTms}, 8'h01);
        walk(8'h06, 4);
        irScan(`AMSB_INS_PPARK);
        walk(8'h1d, 5);
        #30;
        chk({5'h00, lspTms}, 8'h00);
        walk(8'h0a, 4);
        #30;
        chk({5'h00, lspTms}, 8'h01);
        walk(8'h01, 2);
        irScan(`AMSB_INS_GOWAIT);
        walk(8'h01, 1);
        #30;
        chk({5'h00, lspTms}, 8'h00);
        walk(8'h06, 4);
    endtask
    task automatic test_tmsreset();
        irScan({SLOT, 2'h0});
        walk(8'h3f, 6);
        chk({7'h00, selected}, 8'h00);
        walk(8'h00, 1);
    endtask
    // Mode 3'b011 then connect: ports 0 and 1 both follow mode select
    task automatic test_mode();
        irScan({SLOT, 2'h0});
        irScan(`AMSB_INS_MODSEL);
        walk(8'h01, 3);
        for (int i = 0; i < 3; i++) begin
            u_amsb_ctrl_model.step(i == 2, i < 2, dmy);
        end
        walk(8'h01, 2);
        irScan(`AMSB_INS_UNPARK);
        walk(8'h02, 2);
        #30;
        chk({5'h00, lspTms}, 8'h03);
        walk(8'h06, 4);
    endtask
    initial begin
        repeat (20) @(posedge clk);
        #1 reset_n = 1'b1;
        repeat (8) @(posedge clk);
        chk({5'h00, lspTms}, 8'h00);
        chk({6'h00, selected, bpTdoOe_n}, 8'h01);
        walk(8'h00, 1);
        test_absent();
        test_select();
        test_bcast();
        test_connect();
        test_tmsreset();
        test_mode();
        final_report();
    end
endmodule
`default_nettype wire
